// *** verilog/sas_pkg.sv ***
// package for the converter sequencer: register map, fields, states, carriers
// assumes a 16-bit register port with read data one cycle after the read strobe
package sas_pkg;
   // register offsets
   localparam logic [3:0] OFS_CONTROL_ONE = 4'h0;
   localparam logic [3:0] OFS_CONTROL_TWO = 4'h1;
   localparam logic [3:0] OFS_CONTROL_THREE = 4'h2;
   localparam logic [3:0] OFS_INPUT_SELECT = 4'h3;
   localparam logic [3:0] OFS_PIN_CONFIG = 4'h4;
   localparam logic [3:0] OFS_SCAN_MASK = 4'h5;
   // result buffer occupies addresses 0x10..0x1f (address bit 4 set)
   localparam int BUF_DEPTH = 16;
   localparam int RES_W = 12;
   // control one fields
   localparam int C1_ON = 15;
   localparam int C1_FORMAT_SELECT_FIELD_LO = 8;
   localparam int C1_TRIGGER_SOURCE_FIELD_LO = 5;
   localparam int C1_AUTO_SAMPLE_BIT = 2;
   localparam int C1_SAMPLE_CONTROL_BIT = 1;
   localparam int C1_DONE = 0;
   // control two fields
   localparam int C2_SCAN = 10;
   localparam int C2_BUFS = 7;
   localparam int C2_SAMPLES_PER_IRQ_FIELD_LO = 2;
   localparam int C2_BUFFER_SPLIT_BIT = 1;
   localparam int C2_INPUT_ALTERNATE_BIT = 0;
   // control three fields
   localparam int C3_AUTO_SAMPLE_TIME_FIELD_LO = 8;
   localparam int C3_RC = 7;
   localparam int C3_DIV_LO = 0;
   // input select fields
   localparam int IS_B_LO = 8;
   localparam int IS_A_LO = 0;
   // reset values
   localparam logic [15:0] RST_REG = 16'h0000;
   // trigger sources
   localparam logic [2:0] TRG_SOFT = 3'h0;
   localparam logic [2:0] TRG_TIMER = 3'h2;
   localparam logic [2:0] TRG_EXT = 3'h1;
   localparam logic [2:0] TRG_AUTO = 3'h7;
   // timing in converter clock periods
   localparam logic [4:0] SOFT_DELAY_TAD = 5'h0b;
   localparam logic [4:0] CONV_TAD = 5'h0e;
   // output formats
   localparam logic [1:0] FMT_INT = 2'h0;
   localparam logic [1:0] FMT_SINT = 2'h1;
   localparam logic [1:0] FMT_FRAC = 2'h2;
   localparam logic [1:0] FMT_SFRAC = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_DELAY = 2'b10,
      ST_CONVERT = 2'b11
   } sas_state_t;

   // request toward the analog side
   typedef struct packed {
      logic sample;
      logic convert;
      logic [3:0] pos_input;
      logic use_set_b;
   } sas_analog_t;
endpackage : sas_pkg

// *** verilog/sas_sequencer.sv ***
// converter sequencer: registers, trigger handling, input stepping, result store
// assumes synchronous trigger pulses and a converter core that returns its result
// when the convert phase ends
//
// How it works
// RQ1: software leaves config alone while enabled
// RQ2: sixteen twelve-bit results, read only
// RQ3: results read out as sixteen-bit words
// RQ4: setting sample bit starts acquisition
// RQ5: store each result, flag after count
// RQ6: one to sixteen samples per interrupt
// RQ7: split buffer halves alternate per interrupt
// RQ8: count field bits five to two, minus one
// RQ9: alternate off uses first input set only
// RQ10: alternate on swaps sets each sequence
// RQ11: scan steps first set over mask
// RQ12: mask bit one includes that input
// RQ13: ascending scan restarting after each interrupt
// RQ14: software trigger eleven periods after clear
// RQ15: auto trigger after sample time field
// RQ16: software keeps sample time nonzero
// RQ17: timer or external events also trigger
// RQ18: disable aborts, buffer keeps old value
// RQ19: disable beats simultaneous auto start
// RQ20: conversion lasts fourteen converter periods
// RQ21: period is cycle times half field plus one
// RQ22: rc select uses internal rc clock
// RQ23: two-bit field picks output format
// RQ24: enable low means off mode
// RQ25: pointer returns to region start after interrupt
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module sas_sequencer (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic timer_trig_i,
   input wire logic ext_trig_i,
   input wire logic rc_tick_i,
   input wire logic [11:0] conv_result_i,
   output sas_pkg::sas_analog_t analog_o,
   output logic [15:0] pin_analog_o,
   output logic irq_o
);
   logic [15:0] ctl1_r, ctl1_nxt;
   logic [15:0] ctl2_r, ctl2_nxt;
   logic [15:0] ctl3_r, ctl3_nxt;
   logic [15:0] insel_r, insel_nxt;
   logic [15:0] pcfg_r, pcfg_nxt;
   logic [15:0] mask_r, mask_nxt;
   logic [11:0] buf_r [16];
   logic [15:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   sas_pkg::sas_state_t st_r, st_nxt;
   logic [5:0] div_r, div_nxt;
   logic [4:0] tad_r, tad_nxt;
   logic [3:0] wptr_r, wptr_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [3:0] scan_r, scan_nxt;
   logic half_r, half_nxt;
   logic setb_r, setb_nxt;
   logic on;
   logic tick;
   logic store;
   logic irq_evt;
   logic done_set;
   logic trig_ev;
   logic [2:0] trigger_source_field;
   logic [3:0] samples_per_irq_field;
   logic [3:0] next_scan;
   logic [11:0] rd_word;

   assign on = ctl1_r[sas_pkg::C1_ON];
   assign trigger_source_field = ctl1_r[sas_pkg::C1_TRIGGER_SOURCE_FIELD_LO +: 3];
   assign samples_per_irq_field = ctl2_r[sas_pkg::C2_SAMPLES_PER_IRQ_FIELD_LO +: 4]; // see RQ8

   // converter clock tick: divider or rc source
   always_comb begin
      div_nxt = div_r;
      tick = 1'b0;
      if (!on) begin
         div_nxt = 6'h00; // see RQ24
      end else if (ctl3_r[sas_pkg::C3_RC]) begin
         tick = rc_tick_i; // see RQ22
      end else if ((div_r | 6'h01) >= ctl3_r[sas_pkg::C3_DIV_LO +: 6]) begin
         // counts half cycles by twos; period (field+1)/2 cycles, rounded up
         div_nxt = 6'h00; // see RQ21
         tick = 1'b1;
      end else begin
         div_nxt = div_r + 6'h02; // see RQ21
      end
   end

   // next scan input: lowest mask bit above current
   always_comb begin
      next_scan = scan_r;
      for (int i = 15; i >= 0; i--) begin
         if (mask_r[i] && 4'(i) > scan_r) begin
            next_scan = 4'(i); // see RQ12
         end
      end
   end

   function automatic logic [3:0] first_scan(input logic [15:0] m);
      logic [3:0] f;
      f = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) begin
            f = 4'(i);
         end
      end
      return f;
   endfunction : first_scan

   assign trig_ev = (trigger_source_field == sas_pkg::TRG_TIMER && timer_trig_i) ||
                    (trigger_source_field == sas_pkg::TRG_EXT && ext_trig_i); // see RQ17

   // sequencing state machine
   always_comb begin
      st_nxt = st_r;
      tad_nxt = tad_r;
      wptr_nxt = wptr_r;
      cnt_nxt = cnt_r;
      scan_nxt = scan_r;
      half_nxt = half_r;
      setb_nxt = setb_r;
      store = 1'b0;
      irq_evt = 1'b0;
      unique case (st_r)
         sas_pkg::ST_IDLE: begin
            tad_nxt = 5'h00;
            if (on && ctl1_r[sas_pkg::C1_SAMPLE_CONTROL_BIT]) begin
               st_nxt = sas_pkg::ST_SAMPLE; // see RQ4
            end
         end
         sas_pkg::ST_SAMPLE: begin
            if (tick && tad_r != 5'h1f) begin
               tad_nxt = tad_r + 5'h01;
            end
            if (trigger_source_field == sas_pkg::TRG_AUTO) begin
               if (tick && tad_r + 5'h01 >= ctl3_r[sas_pkg::C3_AUTO_SAMPLE_TIME_FIELD_LO +: 5]) begin
                  st_nxt = sas_pkg::ST_CONVERT; // see RQ15
                  tad_nxt = 5'h00;
               end
            end else if (trigger_source_field == sas_pkg::TRG_SOFT) begin
               if (!ctl1_r[sas_pkg::C1_SAMPLE_CONTROL_BIT]) begin
                  st_nxt = sas_pkg::ST_DELAY; // see RQ14
                  tad_nxt = 5'h00;
               end
            end else if (trig_ev) begin
               st_nxt = sas_pkg::ST_CONVERT; // see RQ17
               tad_nxt = 5'h00;
            end
         end
         sas_pkg::ST_DELAY: begin
            if (tick) begin
               tad_nxt = tad_r + 5'h01;
               if (tad_r + 5'h01 == sas_pkg::SOFT_DELAY_TAD) begin
                  st_nxt = sas_pkg::ST_CONVERT; // see RQ14
                  tad_nxt = 5'h00;
               end
            end
         end
         sas_pkg::ST_CONVERT: begin
            if (tick) begin
               tad_nxt = tad_r + 5'h01;
               if (tad_r + 5'h01 == sas_pkg::CONV_TAD) begin
                  store = 1'b1; // see RQ20
                  tad_nxt = 5'h00;
                  wptr_nxt = wptr_r + 4'h1;
                  setb_nxt = ctl2_r[sas_pkg::C2_INPUT_ALTERNATE_BIT] ? !setb_r : 1'b0; // see RQ9 RQ10
                  scan_nxt = next_scan; // see RQ13
                  st_nxt = ctl1_r[sas_pkg::C1_AUTO_SAMPLE_BIT] ? sas_pkg::ST_SAMPLE : sas_pkg::ST_IDLE;
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == samples_per_irq_field) begin
                     irq_evt = 1'b1; // see RQ5 RQ6
                     cnt_nxt = 4'h0;
                     setb_nxt = 1'b0;
                     scan_nxt = first_scan(mask_r); // see RQ13
                     half_nxt = ctl2_r[sas_pkg::C2_BUFFER_SPLIT_BIT] ? !half_r : 1'b0; // see RQ7
                     wptr_nxt = ctl2_r[sas_pkg::C2_BUFFER_SPLIT_BIT] ? {!half_r, 3'h0} : 4'h0; // see RQ25
                  end
               end
            end
         end
      endcase
      if (!on) begin
         // disable wins over any start in the same cycle
         st_nxt = sas_pkg::ST_IDLE; // see RQ18 RQ19
         store = 1'b0; // see RQ18
         irq_evt = 1'b0;
         tad_nxt = 5'h00;
         cnt_nxt = 4'h0;
         setb_nxt = 1'b0;
         half_nxt = 1'b0;
         wptr_nxt = 4'h0;
         scan_nxt = first_scan(mask_r);
      end
   end

   assign done_set = irq_evt;

   // register file with hardware updates to sample, done and C2_BUFS bits
   always_comb begin
      ctl1_nxt = ctl1_r;
      ctl2_nxt = ctl2_r;
      ctl3_nxt = ctl3_r;
      insel_nxt = insel_r;
      pcfg_nxt = pcfg_r;
      mask_nxt = mask_r;
      if (wr_i && !addr_i[4]) begin
         unique case (addr_i[3:0])
            sas_pkg::OFS_CONTROL_ONE: ctl1_nxt = wdata_i;
            sas_pkg::OFS_CONTROL_TWO: ctl2_nxt = wdata_i;
            sas_pkg::OFS_CONTROL_THREE: ctl3_nxt = wdata_i;
            sas_pkg::OFS_INPUT_SELECT: insel_nxt = wdata_i;
            sas_pkg::OFS_PIN_CONFIG: pcfg_nxt = wdata_i;
            sas_pkg::OFS_SCAN_MASK: mask_nxt = wdata_i;
            default: ;
         endcase
      end
      // auto sampling rearms the sample bit after each conversion
      if (store && ctl1_r[sas_pkg::C1_AUTO_SAMPLE_BIT]) begin
         ctl1_nxt[sas_pkg::C1_SAMPLE_CONTROL_BIT] = 1'b1;
      end
      if (done_set) begin
         ctl1_nxt[sas_pkg::C1_DONE] = 1'b1; // see RQ5
      end
      ctl2_nxt[sas_pkg::C2_BUFS] = half_r;
   end

   // read path and format; writes never reach the buffer
   assign rd_word = buf_r[addr_i[3:0]]; // see RQ2
   always_comb begin
      rdata_nxt = 16'h0000;
      if (rd_i && addr_i[4]) begin
         unique case (ctl1_r[sas_pkg::C1_FORMAT_SELECT_FIELD_LO +: 2]) // see RQ3 RQ23
            sas_pkg::FMT_INT: rdata_nxt = {4'h0, rd_word};
            sas_pkg::FMT_SINT: rdata_nxt = {{4{!rd_word[11]}}, !rd_word[11], rd_word[10:0]};
            sas_pkg::FMT_FRAC: rdata_nxt = {rd_word, 4'h0};
            sas_pkg::FMT_SFRAC: rdata_nxt = {!rd_word[11], rd_word[10:0], 4'h0};
         endcase
      end else if (rd_i) begin
         unique case (addr_i[3:0])
            sas_pkg::OFS_CONTROL_ONE: rdata_nxt = ctl1_r;
            sas_pkg::OFS_CONTROL_TWO: rdata_nxt = ctl2_r;
            sas_pkg::OFS_CONTROL_THREE: rdata_nxt = ctl3_r;
            sas_pkg::OFS_INPUT_SELECT: rdata_nxt = insel_r;
            sas_pkg::OFS_PIN_CONFIG: rdata_nxt = pcfg_r;
            sas_pkg::OFS_SCAN_MASK: rdata_nxt = mask_r;
            default: rdata_nxt = 16'h0000;
         endcase
      end
      irq_nxt = irq_evt; // see RQ5
   end

   // result storage, one entry per index
   for (genvar g = 0; g < sas_pkg::BUF_DEPTH; g++) begin : g_buf
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            buf_r[g] <= 12'h000;
         end else if (store && wptr_r == 4'(g)) begin
            buf_r[g] <= conv_result_i; // see RQ5
         end
      end
   end

   // control and status registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl1_r <= sas_pkg::RST_REG;
         ctl2_r <= sas_pkg::RST_REG;
         ctl3_r <= sas_pkg::RST_REG;
         insel_r <= sas_pkg::RST_REG;
         pcfg_r <= sas_pkg::RST_REG;
         mask_r <= sas_pkg::RST_REG;
      end else begin
         ctl1_r <= ctl1_nxt;
         ctl2_r <= ctl2_nxt;
         ctl3_r <= ctl3_nxt;
         insel_r <= insel_nxt;
         pcfg_r <= pcfg_nxt;
         mask_r <= mask_nxt;
      end
   end

   // read data and interrupt pulse
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_r <= 16'h0000;
         irq_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   // converter clock divider
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_r <= 6'h00;
      end else begin
         div_r <= div_nxt;
      end
   end

   // sequencing state, pointers and counters
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= sas_pkg::ST_IDLE;
         tad_r <= 5'h00;
         wptr_r <= 4'h0;
         cnt_r <= 4'h0;
         scan_r <= 4'h0;
         half_r <= 1'b0;
         setb_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tad_r <= tad_nxt;
         wptr_r <= wptr_nxt;
         cnt_r <= cnt_nxt;
         scan_r <= scan_nxt;
         half_r <= half_nxt;
         setb_r <= setb_nxt;
      end
   end

   // input selection toward the analog side
   always_comb begin
      analog_o.sample = (st_r == sas_pkg::ST_SAMPLE);
      analog_o.convert = (st_r == sas_pkg::ST_CONVERT);
      analog_o.use_set_b = setb_r; // see RQ10
      if (setb_r) begin
         analog_o.pos_input = insel_r[sas_pkg::IS_B_LO +: 4];
      end else if (ctl2_r[sas_pkg::C2_SCAN]) begin
         analog_o.pos_input = scan_r; // see RQ11
      end else begin
         analog_o.pos_input = insel_r[sas_pkg::IS_A_LO +: 4]; // see RQ9
      end
   end

   assign rdata_o = rdata_r;
   assign pin_analog_o = ~pcfg_r;
   assign irq_o = irq_r;
endmodule : sas_sequencer

// *** test/sas_sequencer_checker.sv ***
// assertion checker for the converter sequencer, bound to its ports
// assumes config reaches the block only through the register port
`timescale 1ns/1ps
module sas_sequencer_checker (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire sas_pkg::sas_analog_t analog_o,
   input wire logic irq_o
);
   logic [15:0] c1_r;
   logic input_alternate_bit_r;
   // shadow of control one and the alternate bit
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         c1_r <= 16'h0000;
         input_alternate_bit_r <= 1'b0;
      end else if (wr_i && addr_i == 5'h00) begin
         c1_r <= wdata_i;
      end else if (wr_i && addr_i == 5'h01) begin
         input_alternate_bit_r <= wdata_i[0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_rd_idle; !rd_i |=> rdata_o == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
   property p_conv_len;
      disable iff (!reset_n_i || !c1_r[15])
      $rose(analog_o.convert) |-> analog_o.convert [*8] ##[6:1000] !analog_o.convert;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("convert length");
   property p_excl; !(analog_o.sample && analog_o.convert); endproperty
   a_excl: assert property (p_excl) else $error("sample and convert");
   property p_irq_pulse; irq_o |=> !irq_o; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_irq_src;
      $rose(irq_o) |-> $past(analog_o.convert) || $past(analog_o.convert, 2);
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("irq without convert");
   property p_off;
      wr_i && addr_i == 5'h00 && !wdata_i[15] |=> ##1
         !analog_o.sample && !analog_o.convert && !irq_o;
   endproperty
   a_off: assert property (p_off) else $error("active while off");
   property p_soft;
      c1_r[15] && c1_r[7:5] == 3'h0 && $fell(analog_o.sample) |->
         !analog_o.convert [*8] ##[3:1000] analog_o.convert;
   endproperty
   a_soft: assert property (p_soft) else $error("soft delay");
   property p_first_input_set; c1_r[15] && !input_alternate_bit_r && analog_o.sample |-> !analog_o.use_set_b; endproperty
   a_first_input_set: assert property (p_first_input_set) else $error("second set used");
   c_irq: cover property (irq_o);
   c_abort: cover property (analog_o.convert && wr_i && addr_i == 5'h00 && !wdata_i[15]);
   c_setb: cover property (analog_o.sample && analog_o.use_set_b);
endmodule : sas_sequencer_checker
bind sas_sequencer sas_sequencer_checker chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .analog_o(analog_o), .irq_o(irq_o));

// *** test/sas_core_model.sv ***
// behavioural converter core: result encodes the input held at sampling
// assumes the result is taken while convert is high or one cycle after
`timescale 1ns/1ps
module sas_core_model (
   input wire logic clk_i,
   input wire sas_pkg::sas_analog_t analog_i,
   output logic [11:0] result_o
);
   logic [4:0] sel_r = 5'h00;
   logic conv_d = 1'b0;
   logic [11:0] res_r = 12'h000;
   assign result_o = res_r;
   always @(posedge clk_i) begin
      conv_d <= analog_i.convert;
      if (analog_i.sample) begin
         sel_r <= {analog_i.use_set_b, analog_i.pos_input};
      end
      // outside conversions the line churns
      if (analog_i.convert || conv_d) begin
         res_r <= {3'h5, sel_r, 4'h3};
      end else begin
         res_r <= ~res_r;
      end
   end
endmodule : sas_core_model

// *** test/sas_sequencer_bench.sv ***
// self-checking bench for the converter sequencer
// assumes the core model on the result input and one 25 MHz clock
`timescale 1ns/1ps
module sas_sequencer_bench;
   logic clk_i, reset_n_i, wr_i, rd_i, timer_trig_i, ext_trig_i, rc_tick_i, irq_o, rd_seen;
   logic [4:0] addr_i;
   logic [15:0] wdata_i, rdata_o, pin_analog_o;
   logic [11:0] conv_result_i, d;
   logic [3:0] in_a;
   sas_pkg::sas_analog_t analog_o;
   logic [15:0] exp_q[$];
   int error_cnt, checks_done;
   int conv_cnt, conv_last;
   logic [15:0] pc;
   sas_sequencer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .timer_trig_i(timer_trig_i), .ext_trig_i(ext_trig_i), .rc_tick_i(rc_tick_i),
      .conv_result_i(conv_result_i), .analog_o(analog_o), .pin_analog_o(pin_analog_o),
      .irq_o(irq_o));
   sas_core_model core (.clk_i(clk_i), .analog_i(analog_o), .result_o(conv_result_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   always @(posedge clk_i) rd_seen <= rd_i;
   always @(posedge clk_i) rc_tick_i <= 1'($urandom % 2);
   // length of the last convert phase in clock cycles
   always @(posedge clk_i) begin
      if (analog_o.convert === 1'b1) begin
         conv_cnt <= conv_cnt + 1;
      end else if (conv_cnt != 0) begin
         conv_last <= conv_cnt;
         conv_cnt <= 0;
      end
   end
   always @(negedge clk_i) if (rd_seen === 1'b1) check(rdata_o, exp_q.pop_front());
   task wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask : rd
   task wait_irq(input int n, input logic e);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge clk_i);
         if (irq_o === 1'b1) break;
      end
      check({15'h0000, i < n}, {15'h0000, e});
   endtask : wait_irq
   function logic [11:0] res(input logic b, input logic [3:0] s);
      return {3'h5, b, s, 4'h3};
   endfunction : res
   task end_sim;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial begin
      #(40 * 30000);
      error_cnt++;
      end_sim();
   end
   initial begin
      {reset_n_i, wr_i, rd_i, timer_trig_i, ext_trig_i} = 5'h00;
      addr_i = 5'h00;
      wdata_i = 16'h0000;
      void'($urandom(32'h467a90bf));
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      for (int a = 0; a < 6; a++) rd(5'(a), 16'h0000);
      pc = 16'($urandom);
      wr(5'h04, pc);
      @(negedge clk_i);
      check(pin_analog_o, ~pc);
      rd(5'h04, pc);
      in_a = 4'($urandom);
      wr(5'h03, {12'h000, in_a});
      wr(5'h00, 16'h8002);
      repeat (4) @(posedge clk_i);
      wr(5'h00, 16'h8000);
      wait_irq(60, 1'b1);
      d = res(1'b0, in_a);
      rd(5'h00, 16'h8001);
      check(16'(conv_last), 16'h000e);
      for (int f = 0; f < 4; f++) begin
         wr(5'h00, 16'h8000 | 16'(f << 8));
         rd(5'h10, f == 0 ? {4'h0, d} : f == 1 ? {{5{~d[11]}}, d[10:0]} :
            f == 2 ? {d, 4'h0} : {~d[11], d[10:0], 4'h0});
      end
      wr(5'h00, 16'h8000);
      wr(5'h10, 16'($urandom));
      rd(5'h10, {4'h0, d});
      wr(5'h00, 16'h0000);
      wr(5'h05, 16'h124a);
      wr(5'h02, 16'h0100);
      wr(5'h01, 16'h040c);
      wr(5'h00, 16'h80e6);
      wait_irq(200, 1'b1);
      wr(5'h00, 16'h0000);
      for (int i = 0; i < 4; i++) rd(5'h10 + 5'(i), {4'h0, res(1'b0, 4'(16'h9631 >> (4 * i)))});
      wr(5'h01, 16'h0007);
      wr(5'h03, 16'h0702);
      wr(5'h00, 16'h80e6);
      wait_irq(200, 1'b1);
      wait_irq(200, 1'b1);
      wr(5'h00, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         rd(5'h10 + 5'(i[1] * 8 + i[0]), {4'h0, res(i[0], i[0] ? 4'h7 : 4'h2)});
      end
      wr(5'h01, 16'h0000);
      for (int t = 0; t < 2; t++) begin
         wr(5'h02, t == 1 ? 16'h0080 : 16'h0000);
         in_a = 4'($urandom);
         wr(5'h03, {12'h000, in_a});
         wr(5'h00, t == 0 ? 16'h8042 : 16'h8022);
         repeat (3) @(posedge clk_i);
         timer_trig_i <= (t == 0);
         ext_trig_i <= (t == 1);
         @(posedge clk_i);
         timer_trig_i <= 1'b0;
         ext_trig_i <= 1'b0;
         wait_irq(300, 1'b1);
         wr(5'h00, 16'h0000);
         rd(5'h10, {4'h0, res(1'b0, in_a)});
      end
      wr(5'h02, 16'h0003);
      wr(5'h00, 16'h8002);
      repeat (3) @(posedge clk_i);
      wr(5'h00, 16'h8000);
      wait_irq(200, 1'b1);
      wr(5'h00, 16'h0000);
      check(16'(conv_last), 16'h001c);
      wr(5'h02, 16'h0000);
      wr(5'h03, 16'h0004);
      wr(5'h00, 16'h8002);
      repeat (3) @(posedge clk_i);
      wr(5'h00, 16'h8000);
      repeat (16) @(posedge clk_i);
      wr(5'h00, 16'h0000);
      wait_irq(40, 1'b0);
      rd(5'h10, {4'h0, res(1'b0, in_a)});
      repeat (3) @(posedge clk_i);
      end_sim();
   end
endmodule : sas_sequencer_bench
